// ==== common/tsac_cfg.svh ====
// Offsets, field positions, reset values and counts of the alert/standby block.
`ifndef TSAC_CFG_SVH
`define TSAC_CFG_SVH

// ============================================================
// Register offsets, read side
`define TSAC_RD_LOCAL_TEMP 8'h00
`define TSAC_RD_REMOTE_TEMP 8'h01
`define TSAC_RD_STATUS 8'h02
`define TSAC_RD_CONFIG 8'h03
`define TSAC_RD_LOCAL_HIGH 8'h05
`define TSAC_RD_LOCAL_LOW 8'h06
`define TSAC_RD_REMOTE_HIGH 8'h07
`define TSAC_RD_REMOTE_LOW 8'h08

// ============================================================
// Register offsets, write side
`define TSAC_WR_CONFIG 8'h09
`define TSAC_WR_LOCAL_HIGH 8'h0b
`define TSAC_WR_LOCAL_LOW 8'h0c
`define TSAC_WR_REMOTE_HIGH 8'h0d
`define TSAC_WR_REMOTE_LOW 8'h0e
`define TSAC_WR_ONE_SHOT 8'h0f

// ============================================================
// Field positions
`define TSAC_CFG_STANDBY_BIT 6
`define TSAC_ST_LOCAL_HIGH_BIT 6
`define TSAC_ST_LOCAL_LOW_BIT 5
`define TSAC_ST_REMOTE_HIGH_BIT 4
`define TSAC_ST_REMOTE_LOW_BIT 3
`define TSAC_ST_OPEN_BIT 2

// ============================================================
// Reset values and codes
`define TSAC_CONFIG_RST 8'h00
`define TSAC_HIGH_LIMIT_RST 8'h7f
`define TSAC_LOW_LIMIT_RST 8'hc9
`define TSAC_UNDERRANGE_CODE 8'h80
`define TSAC_TEMP_RST 8'h00

// ============================================================
// Cycles between conversion rounds in normal operation
`define TSAC_CONV_GAP_CYC 1000

`endif

// ==== common/tsac_pkg.sv ====
// Types shared by the alert/standby block.
package tsac_pkg;

    // Conversion sequencer states.
    typedef enum logic [1:0]
    {
        TSAC_IDLE,
        TSAC_LOCAL,
        TSAC_REMOTE
    } tsac_state_e;

    typedef logic [7:0] tsac_byte_t;

endpackage

// ==== design/tsac_limit_cmp.sv ====
// Signed window comparator for one temperature channel.
`timescale 1ns/1ns

module tsac_limit_cmp
    import tsac_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic [WIDTH-1:0] value_i,
    input wire logic [WIDTH-1:0] high_i,
    input wire logic [WIDTH-1:0] low_i,
    output logic over_o,
    output logic under_o
);

    // ============================================================
    // Comparison
    // Two's complement compare; equality to a limit is not a fault.
    // [R17] strict comparisons
    assign over_o = $signed(value_i) > $signed(high_i);
    assign under_o = $signed(value_i) < $signed(low_i);

endmodule

// ==== design/tsac_alert_standby.sv ====
// Alert, standby and sensor-fault control of a two-channel monitor.
`timescale 1ns/1ns
`include "tsac_cfg.svh"

// Function
// [R1] Pull alert low on any limit violation or open remote diode.
// [R2] Alert pin is open-drain: only drive low or release.
// [R3] Master reads alert response address when shared alert line falls.
// [R4] When alerting, acknowledge alert response read and return own address.
// [R5] Arbitration by the bus front end decides who answers; lowest wins.
// [R6] After answering, release alert only if the cause is gone.
// [R7] Master repeats alert response reads while shared line stays low.
// [R8] Standby when pin low or config bit 6 set; else normal.
// [R9] Entering standby aborts conversion without updating the value register.
// [R10] Register access keeps working in both standby modes.
// [R11] Pin standby blocks every conversion, one-shot included.
// [R12] One-shot write in software standby starts one two-channel conversion.
// [R13] Sample open-diode comparator at conversion start into status bit 2.
// [R14] Remote under-range reading is stored as 80h.
// [R15] Shorted remote alerts through the ordinary low-limit comparison.
// [R16] Host may clear an unused shorted channel by writing 80h low limit.
// [R17] High fault only when above limit, low fault only when below.
// [R18] One-shot data is not stored; device returns to standby after.
// [R19] Standby request is pin low OR config bit 6, continuously.
// [R20] Alert stays latched until an alert response read is answered.
module tsac_alert_standby
    import tsac_pkg::*;
#(
    parameter int CONV_GAP_CYC = `TSAC_CONV_GAP_CYC
)
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic sleep_request_n_i,
    input wire logic [6:0] dev_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic ara_req_i,
    input wire logic ara_done_i,
    input wire logic ara_lost_i,
    output logic ara_ack_o,
    output logic [6:0] ara_addr_o,
    output logic adc_start_o,
    output logic adc_abort_o,
    output logic adc_remote_o,
    input wire logic adc_done_i,
    input wire logic [7:0] adc_data_i,
    input wire logic adc_underrange_i,
    input wire logic open_fault_i,
    output logic standby_o,
    output logic alert_o,
    output logic alert_oe_o
);
    localparam logic [15:0] GAP_LAST = 16'(CONV_GAP_CYC - 1);
    tsac_state_e state_reg, state_next;
    logic oneshot_run_reg, oneshot_run_next;
    logic [15:0] gap_cnt_reg, gap_cnt_next;
    logic start_reg, start_next, abort_reg, abort_next;
    tsac_byte_t local_temp_reg, local_temp_next;
    tsac_byte_t remote_temp_reg, remote_temp_next;
    logic open_flt_reg, open_flt_next, alert_reg, alert_next;
    tsac_byte_t cfg_reg, cfg_next, rdata_reg, rdata_next;
    tsac_byte_t lhigh_reg, lhigh_next, llow_reg, llow_next;
    tsac_byte_t rhigh_reg, rhigh_next, rlow_reg, rlow_next;
    logic [6:0] addr_reg, addr_next;
    logic addr_taken_reg, addr_taken_next;
    logic standby_req, pin_sleep, oneshot_ok;
    logic l_over, l_under, r_over, r_under, alert_cause;
    tsac_byte_t status_val;
    // ============================================================
    // Limit comparators on the stored readings
    // [R15] remote low compare
    tsac_limit_cmp #(.WIDTH(8)) u_cmp_local (
        .value_i(local_temp_reg),
        .high_i(lhigh_reg),
        .low_i(llow_reg),
        .over_o(l_over),
        .under_o(l_under)
    );
    tsac_limit_cmp #(.WIDTH(8)) u_cmp_remote (
        .value_i(remote_temp_reg),
        .high_i(rhigh_reg),
        .low_i(rlow_reg),
        .over_o(r_over),
        .under_o(r_under)
    );
    // ============================================================
    // Standby request and one-shot qualification
    // [R19] pin OR bit
    assign pin_sleep = ~sleep_request_n_i;
    // [R8] standby from either source
    assign standby_req = pin_sleep | cfg_reg[`TSAC_CFG_STANDBY_BIT];
    // [R11] pin blocks one-shot
    assign oneshot_ok = reg_wr_i & (reg_addr_i == `TSAC_WR_ONE_SHOT)
        & cfg_reg[`TSAC_CFG_STANDBY_BIT] & ~pin_sleep;
    // Status byte assembled from live limit flags and the sampled open-diode flag.
    always_comb
    begin
        status_val = 8'h00;
        status_val[`TSAC_ST_LOCAL_HIGH_BIT] = l_over;
        status_val[`TSAC_ST_LOCAL_LOW_BIT] = l_under;
        status_val[`TSAC_ST_REMOTE_HIGH_BIT] = r_over;
        status_val[`TSAC_ST_REMOTE_LOW_BIT] = r_under;
        status_val[`TSAC_ST_OPEN_BIT] = open_flt_reg;
    end
    // [R1] any fault raises alert
    assign alert_cause = l_over | l_under | r_over | r_under | open_flt_reg;
    // ============================================================
    // Conversion sequencer, next state
    always_comb
    begin
        state_next = state_reg;
        oneshot_run_next = oneshot_run_reg;
        gap_cnt_next = gap_cnt_reg;
        start_next = 1'b0;
        abort_next = 1'b0;
        local_temp_next = local_temp_reg;
        remote_temp_next = remote_temp_reg;
        open_flt_next = open_flt_reg;
        case (state_reg)
            TSAC_IDLE:
            begin
                // A one-shot has priority over the timed start.
                if (oneshot_ok || (!standby_req && gap_cnt_reg >= GAP_LAST))
                begin
                    // [R12] one-shot start
                    state_next = TSAC_LOCAL;
                    oneshot_run_next = oneshot_ok;
                    start_next = 1'b1;
                    gap_cnt_next = 16'h0000;
                    // [R13] sample open comparator
                    open_flt_next = open_fault_i;
                end
                else if (standby_req)
                    gap_cnt_next = 16'h0000;
                else
                    gap_cnt_next = gap_cnt_reg + 16'h0001;
            end
            TSAC_LOCAL, TSAC_REMOTE:
            begin
                if (pin_sleep || (standby_req && !oneshot_run_reg))
                begin
                    // [R9] abort without storing
                    state_next = TSAC_IDLE;
                    abort_next = 1'b1;
                    oneshot_run_next = 1'b0;
                end
                else if (adc_done_i && state_reg == TSAC_LOCAL)
                begin
                    local_temp_next = adc_data_i;
                    state_next = TSAC_REMOTE;
                    start_next = 1'b1;
                end
                else if (adc_done_i)
                begin
                    // [R14] under-range code
                    remote_temp_next = adc_underrange_i
                        ? `TSAC_UNDERRANGE_CODE : adc_data_i;
                    // [R18] back to standby
                    state_next = TSAC_IDLE;
                    oneshot_run_next = 1'b0;
                end
            end
            default:
                state_next = TSAC_IDLE;
        endcase
    end
    // ============================================================
    // Register file, next values
    // Writes are taken in every mode, so standby never locks the host out.
    always_comb
    begin
        cfg_next = cfg_reg;
        lhigh_next = lhigh_reg;
        llow_next = llow_reg;
        rhigh_next = rhigh_reg;
        rlow_next = rlow_reg;
        rdata_next = rdata_reg;
        // [R10] access in standby
        if (reg_wr_i)
        begin
            if (reg_addr_i == `TSAC_WR_CONFIG)
                cfg_next = reg_wdata_i;
            else if (reg_addr_i == `TSAC_WR_LOCAL_HIGH)
                lhigh_next = reg_wdata_i;
            else if (reg_addr_i == `TSAC_WR_LOCAL_LOW)
                llow_next = reg_wdata_i;
            else if (reg_addr_i == `TSAC_WR_REMOTE_HIGH)
                rhigh_next = reg_wdata_i;
            // [R16] low limit writable
            else if (reg_addr_i == `TSAC_WR_REMOTE_LOW)
                rlow_next = reg_wdata_i;
            // [R18] one-shot byte dropped
        end
        if (reg_rd_i)
        begin
            if (reg_addr_i == `TSAC_RD_LOCAL_TEMP)
                rdata_next = local_temp_reg;
            else if (reg_addr_i == `TSAC_RD_REMOTE_TEMP)
                rdata_next = remote_temp_reg;
            else if (reg_addr_i == `TSAC_RD_STATUS)
                rdata_next = status_val;
            else if (reg_addr_i == `TSAC_RD_CONFIG)
                rdata_next = cfg_reg;
            else if (reg_addr_i == `TSAC_RD_LOCAL_HIGH)
                rdata_next = lhigh_reg;
            else if (reg_addr_i == `TSAC_RD_LOCAL_LOW)
                rdata_next = llow_reg;
            else if (reg_addr_i == `TSAC_RD_REMOTE_HIGH)
                rdata_next = rhigh_reg;
            else if (reg_addr_i == `TSAC_RD_REMOTE_LOW)
                rdata_next = rlow_reg;
            else
                rdata_next = 8'h00;
        end
    end
    // ============================================================
    // Alert latch and device address capture, next values
    always_comb
    begin
        // [R20] hold until answered
        // [R6] release only if cleared
        // A new cause in the answering cycle keeps the alert set.
        alert_next = alert_cause
            | (alert_reg & ~(ara_done_i & ~ara_lost_i));
        addr_next = addr_reg;
        addr_taken_next = 1'b1;
        // Address straps are caught once, on the first edge after reset.
        if (!addr_taken_reg)
            addr_next = dev_addr_i;
    end
    // ============================================================
    // State registers
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= TSAC_IDLE;
            oneshot_run_reg <= 1'b0;
            gap_cnt_reg <= 16'h0000;
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
            local_temp_reg <= `TSAC_TEMP_RST;
            remote_temp_reg <= `TSAC_TEMP_RST;
            open_flt_reg <= 1'b0;
            alert_reg <= 1'b0;
            cfg_reg <= `TSAC_CONFIG_RST;
            lhigh_reg <= `TSAC_HIGH_LIMIT_RST;
            llow_reg <= `TSAC_LOW_LIMIT_RST;
            rhigh_reg <= `TSAC_HIGH_LIMIT_RST;
            rlow_reg <= `TSAC_LOW_LIMIT_RST;
            rdata_reg <= 8'h00;
            addr_reg <= 7'h00;
            addr_taken_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            oneshot_run_reg <= oneshot_run_next;
            gap_cnt_reg <= gap_cnt_next;
            start_reg <= start_next;
            abort_reg <= abort_next;
            local_temp_reg <= local_temp_next;
            remote_temp_reg <= remote_temp_next;
            open_flt_reg <= open_flt_next;
            alert_reg <= alert_next;
            cfg_reg <= cfg_next;
            lhigh_reg <= lhigh_next;
            llow_reg <= llow_next;
            rhigh_reg <= rhigh_next;
            rlow_reg <= rlow_next;
            rdata_reg <= rdata_next;
            addr_reg <= addr_next;
            addr_taken_reg <= addr_taken_next;
        end
    end
    // ============================================================
    // Outputs
    // [R4] answer when alerting
    // [R5] front end arbitrates
    assign ara_ack_o = ara_req_i & alert_reg;
    assign ara_addr_o = addr_reg;
    assign adc_start_o = start_reg;
    assign adc_abort_o = abort_reg;
    assign adc_remote_o = (state_reg == TSAC_REMOTE);
    assign standby_o = standby_req;
    assign reg_rdata_o = rdata_reg;
    // [R2] open-drain drive
    assign alert_o = 1'b0;
    assign alert_oe_o = alert_reg;
endmodule

// ==== verification/tsac_alert_standby_asserts.sv ====
// Port-level checker for the alert/standby block, bound to its top.
`timescale 1ns/1ns

module tsac_alert_standby_asserts
    import tsac_pkg::*;
#(
    parameter int CONV_GAP_CYC = 1000
)
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic sleep_request_n_i,
    input wire logic [6:0] dev_addr_i,
    input wire logic ara_req_i,
    input wire logic ara_done_i,
    input wire logic ara_lost_i,
    input wire logic ara_ack_o,
    input wire logic [6:0] ara_addr_o,
    input wire logic adc_start_o,
    input wire logic adc_abort_o,
    input wire logic adc_remote_o,
    input wire logic adc_done_i,
    input wire logic standby_o,
    input wire logic alert_o,
    input wire logic alert_oe_o
);
    // ============================================================
    // Relations between the block's ports, one clock domain.
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    a_alert_never_high: assert property (alert_o == 1'b0)
        else $error("Alert pin data is not low.");
    a_ack_needs_alert: assert property
        (ara_ack_o == (ara_req_i && alert_oe_o))
        else $error("Alert response acknowledge disagrees with alert.");
    a_ack_own_addr: assert property
        (ara_ack_o |-> ara_addr_o == dev_addr_i)
        else $error("Alert response carries a wrong address.");
    a_alert_holds: assert property
        (alert_oe_o && !(ara_done_i && !ara_lost_i) |=> alert_oe_o)
        else $error("Alert released without a won response.");
    a_alert_release: assert property
        ($fell(alert_oe_o) |-> $past(ara_done_i && !ara_lost_i))
        else $error("Alert fell without a finished response.");
    a_pin_blocks_start: assert property
        (!sleep_request_n_i && $past(!sleep_request_n_i) |-> !adc_start_o)
        else $error("Conversion started while the pin holds standby.");
    a_remote_after_local: assert property
        (adc_start_o && adc_remote_o |-> $past(adc_done_i && !adc_remote_o))
        else $error("Remote conversion not right after local.");
    a_start_single: assert property (adc_start_o |=> !adc_start_o)
        else $error("Start pulse longer than one cycle.");
    a_abort_in_standby: assert property (adc_abort_o |-> $past(standby_o))
        else $error("Abort without a standby request.");
    a_standby_pin: assert property (!sleep_request_n_i |-> standby_o)
        else $error("Pin standby not reflected.");

    // Main scenarios reached.
    c_lost_arb: cover property (ara_ack_o && ara_done_i && ara_lost_i);
    c_abort: cover property (adc_abort_o);
    c_remote: cover property (adc_start_o && adc_remote_o);
endmodule

bind tsac_alert_standby tsac_alert_standby_asserts #(
    .CONV_GAP_CYC(CONV_GAP_CYC)
) chk (.clock_i, .sys_rst_i, .sleep_request_n_i, .dev_addr_i, .ara_req_i,
    .ara_done_i, .ara_lost_i, .ara_ack_o, .ara_addr_o, .adc_start_o,
    .adc_abort_o, .adc_remote_o, .adc_done_i, .standby_o, .alert_o,
    .alert_oe_o);

// ==== verification/tsac_adc_model.sv ====
// Converter stand-in that answers each start that is not aborted after a fixed delay.
`timescale 1ns/1ns

module tsac_adc_model
#(
    parameter int DLY = 20
)
(
    input wire logic clock_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic remote_i,
    input wire logic [7:0] loc_val_i,
    input wire logic [7:0] rem_val_i,
    input wire logic rem_under_i,
    output logic done_o,
    output logic [7:0] data_o,
    output logic under_o
);
    // ============================================================
    // Conversion timing.
    int cnt = 0;
    logic rem = 1'b0;

    initial
    begin
        done_o = 1'b0;
        data_o = 8'h00;
        under_o = 1'b0;
    end

    // Data inverts every cycle outside the done pulse, so a stale value never holds two cycles running.
    always @(posedge clock_i)
    begin
        done_o <= 1'b0;
        under_o <= 1'b0;
        data_o <= ~data_o;
        if (abort_i)
            cnt <= 0;
        else if (start_i)
        begin
            cnt <= DLY;
            rem <= remote_i;
        end
        else if (cnt == 1)
        begin
            cnt <= 0;
            done_o <= 1'b1;
            data_o <= rem ? rem_val_i : loc_val_i;
            under_o <= rem && rem_under_i;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
    end
endmodule

// ==== verification/tb_tsac_alert_standby.sv ====
// Self-checking bench for the alert/standby block.
`timescale 1ns/1ns

module tb_tsac_alert_standby
    import tsac_pkg::*;
;
    // ============================================================
    // Stimulus, models and checks.
    localparam int DLY = 20;
    localparam logic [6:0] DEV = 7'h2a;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic sleep_request_n_i = 1'b0;
    logic [6:0] dev_addr_i = DEV;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
    logic ara_req_i = 1'b0, ara_done_i = 1'b0, ara_lost_i = 1'b0;
    logic open_fault_i = 1'b0, rem_under = 1'b0, seen;
    logic [7:0] loc_val = 8'h00, rem_val = 8'h00, reg_rdata_o, adc_data_i;
    logic [6:0] ara_addr_o;
    logic ara_ack_o, adc_start_o, adc_abort_o, adc_remote_o, adc_done_i;
    logic adc_underrange_i, standby_o, alert_o, alert_oe_o;
    int num_errors = 0;
    int tests_run = 0;

    // Free-running 50 MHz clock.
    initial
        forever #10 clock_i = ~clock_i;

    tsac_alert_standby #(.CONV_GAP_CYC(10)) uut (.clock_i, .sys_rst_i,
        .sleep_request_n_i, .dev_addr_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .ara_req_i, .ara_done_i, .ara_lost_i,
        .ara_ack_o, .ara_addr_o, .adc_start_o, .adc_abort_o, .adc_remote_o,
        .adc_done_i, .adc_data_i, .adc_underrange_i, .open_fault_i,
        .standby_o, .alert_o, .alert_oe_o);

    tsac_adc_model #(.DLY(DLY)) adc (.clock_i, .start_i(adc_start_o),
        .abort_i(adc_abort_o), .remote_i(adc_remote_o), .loc_val_i(loc_val),
        .rem_val_i(rem_val), .rem_under_i(rem_under), .done_o(adc_done_i),
        .data_o(adc_data_i), .under_o(adc_underrange_i));

    task automatic chk(input string what, input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(negedge clock_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, exp);
        @(negedge clock_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge clock_i);
        reg_rd_i = 1'b0;
        chk($sformatf("reg %h", a), reg_rdata_o, exp);
    endtask

    // One alert response read; lost marks a lost arbitration.
    task automatic ara(input logic lost, ack, keep);
        @(negedge clock_i);
        ara_req_i = 1'b1;
        @(negedge clock_i);
        chk("ack", ara_ack_o, ack);
        if (ack)
            chk("ara addr", ara_addr_o, DEV);
        ara_done_i = 1'b1;
        ara_lost_i = lost;
        @(negedge clock_i);
        ara_req_i = 1'b0;
        ara_done_i = 1'b0;
        ara_lost_i = 1'b0;
        chk("alert", alert_oe_o, keep);
    endtask

    task automatic shot();
        wr(8'h0f, 8'hff);
        repeat (2 * DLY + 8) @(negedge clock_i);
    endtask

    task automatic wait_hi(ref logic sig, input int n);
        seen = 1'b0;
        for (int i = 0; i < n && !seen; i++)
        begin
            @(negedge clock_i);
            seen = sig;
        end
    endtask

    task automatic give_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        repeat (2) @(negedge clock_i);
        sys_rst_i = 1'b0;
        for (int i = 0; i < 4; i++)
            rd(8'(5 + i), i[0] ? 8'hc9 : 8'h7f);
        rd(8'h04, 8'h00);
        rd(8'h03, 8'h00);
        chk("standby", standby_o, 1'b1);
        wr(8'h09, 8'h40);
        sleep_request_n_i = 1'b1;
        chk("standby", standby_o, 1'b1);
        wr(8'h0b, 8'h1e);
        loc_val = 8'h1e;
        rem_val = 8'h37;
        rem_under = 1'b1;
        shot();
        rd(8'h00, 8'h1e);
        rd(8'h01, 8'h80);
        rd(8'h02, 8'h08);
        rd(8'h0f, 8'h00);
        wait_hi(adc_start_o, 20);
        chk("start", seen, 1'b0);
        chk("alert", alert_oe_o, 1'b1);
        ara(1'b0, 1'b1, 1'b1);
        wr(8'h0e, 8'h80);
        rd(8'h02, 8'h00);
        ara(1'b1, 1'b1, 1'b1);
        ara(1'b0, 1'b1, 1'b0);
        ara(1'b0, 1'b0, 1'b0);
        loc_val = 8'h1f;
        rem_under = 1'b0;
        open_fault_i = 1'b1;
        shot();
        rd(8'h02, 8'h44);
        chk("alert", alert_oe_o, 1'b1);
        open_fault_i = 1'b0;
        loc_val = 8'h1e;
        shot();
        rd(8'h02, 8'h00);
        chk("alert", alert_oe_o, 1'b1);
        ara(1'b0, 1'b1, 1'b0);
        loc_val = 8'h1f;
        sleep_request_n_i = 1'b0;
        shot();
        rd(8'h00, 8'h1e);
        sleep_request_n_i = 1'b1;
        wr(8'h09, 8'h00);
        wait_hi(adc_start_o, 40);
        chk("start", seen, 1'b1);
        sleep_request_n_i = 1'b0;
        wait_hi(adc_abort_o, 4);
        chk("abort", seen, 1'b1);
        repeat (2 * DLY) @(negedge clock_i);
        rd(8'h00, 8'h1e);
        give_verdict();
    end

    // Cuts a hang short well past the expected run length.
    initial
    begin
        #400000;
        num_errors++;
        give_verdict();
    end
endmodule
